/* hdl/hrecd_dev_end.sv */
// Host instruction decoder: SPI slave with register file and EEPROM store
//
// Overview of operation
// - Opcode 0x17 switches the field off
// - 0x18 digital, 0x19 analog probe bus enable
// - Opcode 0x00 writes 32-bit register, no response
// - Opcode 0x01 ORs mask into register
// - Opcode 0x02 ANDs mask into register
// - Nonexistent register address raises an exception
// - Opcode 0x03 processes up to 42 entries
// - Entry action: 1 write, 2 OR, 3 AND
// - No rollback after a mid-frame exception
// - Opcode 0x04 returns one register, four bytes
// - Opcode 0x05 reads 1 to 18 registers
// - Read values follow request address order
// - Opcode 0x06 writes consecutive EEPROM bytes
// - Host keeps EEPROM writes within address 254
// - Opcode 0x07 returns consecutive EEPROM bytes
// - Host keeps EEPROM reads within address 254
// - Violation sets status cause and interrupt
// - One frame per instruction, second for reads
// - Busy rises on data, falls when ready
// - Four-byte values travel least byte first
`timescale 1ns/1ps
module hrecd_dev_end
  import hrecd_pkg::*;
#(
  parameter int NUM_REGS = REG_COUNT
) (
  // System
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  // Link
  hrecd_link_if.dev link,
  // Decoded instructions
  output logic      field_off_instr,
  output logic      digital_probe_bus_instr,
  output logic      analog_probe_bus_instr
);

  localparam int         AW   = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;
  localparam logic [7:0] NREG = 8'(NUM_REGS);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic              cs_m_ff, cs_s_ff, cs_d_ff;
  logic              sck_m_ff, sck_s_ff, sck_d_ff;
  logic              mosi_m_ff, mosi_s_ff;
  logic [2:0]        bit_ff;
  logic [7:0]        rx_sh_ff;
  logic [7:0]        tx_sh_ff;
  logic [8:0]        cnt_ff;
  logic [8:0]        ridx_ff;
  logic [2:0]        pos_ff;
  logic [6:0]        ent_ff;
  logic [7:0]        opcode_ff;
  logic [7:0]        addr_ff;
  logic [7:0]        act_ff;
  logic [23:0]       val_ff;
  logic [7:0]        ee_ptr_ff;
  logic [7:0]        ee_start_ff;
  logic [7:0]        ee_len_ff;
  logic [4:0]        rd_n_ff;
  logic              bad_rd_ff;
  logic              resp_rdy_ff;
  logic              resp_ee_ff;
  logic              rd_frame_ff;
  logic              busy_ff;
  logic              irq_ff;
  logic              foff_ff, dpb_ff, apb_ff;
  logic [31:0]       regs_ff     [NUM_REGS];
  logic [7:0]        addr_buf_ff [RD_MAX_ADDRS];
  logic [7:0]        ee_ff       [EE_DEPTH];

  // ----------------------------------------------------------------------
  // Link edge and byte decode
  // ----------------------------------------------------------------------
  wire logic       in_frame  = ~cs_s_ff;
  wire logic       cs_fall   = ~cs_s_ff & cs_d_ff;
  wire logic       cs_rise   = cs_s_ff & ~cs_d_ff;
  wire logic       sck_rise  = sck_s_ff & ~sck_d_ff;
  wire logic       sck_fall  = ~sck_s_ff & sck_d_ff;
  wire logic       byte_done = in_frame & sck_rise & (bit_ff == BIT_LAST);
  wire logic [7:0] rx_byte   = {rx_sh_ff[6:0], mosi_s_ff};
  wire logic       cmd_byte  = byte_done & ~rd_frame_ff;
  wire logic       par_byte  = cmd_byte & (cnt_ff != IDX_OPCODE);
  wire logic       load_tx   = cs_fall | byte_done;

  // Opcode decode
  wire logic is_reg_op = opcode_ff <= OP_AND;
  wire logic is_wrm    = opcode_ff == OP_WRM;
  wire logic is_rd     = opcode_ff == OP_RD;
  wire logic is_rdm    = opcode_ff == OP_RDM;
  wire logic is_eew    = opcode_ff == OP_EEW;
  wire logic is_eer    = opcode_ff == OP_EER;
  wire logic is_foff   = opcode_ff == OP_FOFF;
  wire logic is_dpb    = opcode_ff == OP_DPB;
  wire logic is_apb    = opcode_ff == OP_APB;
  wire logic is_short  = is_foff | is_dpb | is_apb;
  wire logic known     = is_reg_op | is_wrm | is_rd | is_rdm | is_eew | is_eer | is_short;

  // ----------------------------------------------------------------------
  // Register update path
  // ----------------------------------------------------------------------
  // single write lands on fifth parameter byte
  wire logic        apply_single = par_byte & is_reg_op & (cnt_ff == IDX_WR_LAST);
  wire logic        apply_multi  = par_byte & is_wrm & (pos_ff == ENT_LAST);
  // single opcodes map onto the entry action codes
  wire logic [7:0]  sel_op       = is_reg_op ? opcode_ff + ACT_WR : act_ff;
  wire logic        act_ok       = (sel_op >= ACT_WR) & (sel_op <= ACT_AND);
  // address must name an existing register
  wire logic        addr_ok      = addr_ff < NREG;
  wire logic        do_apply     = apply_single | (apply_multi & (ent_ff < MAX_ENTRIES));
  wire logic        wr_en        = do_apply & addr_ok & act_ok;
  // last byte is the most significant
  wire logic [31:0] wr_data      = {rx_byte, val_ff};
  wire logic [31:0] old_val      = addr_ok ? regs_ff[addr_ff[AW-1:0]] : REG_RESET;
  wire logic [31:0] new_val      = (sel_op == ACT_OR)  ? (old_val | wr_data) :
                                   (sel_op == ACT_AND) ? (old_val & wr_data) : wr_data;

  // EEPROM write path
  wire logic ee_wr    = par_byte & is_eew & (cnt_ff >= IDX_PARAM2);
  wire logic ee_ok    = ee_ptr_ff <= EE_LAST_ADDR;
  wire logic ee_wr_en = ee_wr & ee_ok;

  // Read address capture
  wire logic       rd_cap  = par_byte & (is_rd | is_rdm) & (cnt_ff < RDM_FRAME_MAX);
  wire logic [4:0] cap_idx = 5'(cnt_ff - IDX_PARAM1);

  // ----------------------------------------------------------------------
  // Frame end checks
  // ----------------------------------------------------------------------
  wire logic frame_end = cs_rise & ~rd_frame_ff & (cnt_ff != IDX_OPCODE);
  wire logic len_ok    = is_reg_op ? (cnt_ff == WR_FRAME_LEN) :
                         is_wrm    ? ((cnt_ff > IDX_PARAM1) & (pos_ff == 3'h0)
                                      & (ent_ff <= MAX_ENTRIES)) :
                         is_rd     ? (cnt_ff == RD_FRAME_LEN) :
                         is_rdm    ? ((cnt_ff >= RD_FRAME_LEN) & (cnt_ff <= RDM_FRAME_MAX)) :
                         is_eew    ? (cnt_ff >= EEW_FRAME_MIN) :
                         is_eer    ? (cnt_ff == EER_FRAME_LEN) :
                                     (cnt_ff == SHORT_FRAME_LEN);
  // read range checked against last EEPROM address
  wire logic ee_rng_ok = (({1'b0, ee_start_ff} + {1'b0, ee_len_ff}) <= EE_END_EXCL)
                         & (ee_len_ff != 8'h00);
  wire logic good_end  = frame_end & known & len_ok;
  wire logic rd_bad    = ((is_rd | is_rdm) & bad_rd_ff) | (is_eer & ~ee_rng_ok);
  wire logic resp_go   = good_end & (is_rd | is_rdm | is_eer) & ~rd_bad;

  wire logic [EXC_W-1:0] exc_set;
  assign exc_set[EXC_OPCODE]  = frame_end & ~known;
  assign exc_set[EXC_LENGTH]  = frame_end & known & ~len_ok;
  assign exc_set[EXC_ADDRESS] = (do_apply & ~addr_ok) | (ee_wr & ~ee_ok) | (good_end & rd_bad);
  assign exc_set[EXC_ACTION]  = do_apply & addr_ok & ~act_ok;

  // ----------------------------------------------------------------------
  // Response byte selection
  // ----------------------------------------------------------------------
  // word index follows request order, byte 0 is least significant
  wire logic [6:0]  r_word   = ridx_ff[8:2];
  wire logic [7:0]  r_sel    = addr_buf_ff[r_word[4:0]];
  wire logic [31:0] r_val    = regs_ff[r_sel[AW-1:0]];
  wire logic [7:0]  reg_byte = r_val[{ridx_ff[1:0], 3'b000} +: 8];
  wire logic [7:0]  ee_byte  = ee_ff[ee_start_ff + ridx_ff[7:0]];
  wire logic        r_in_reg = r_word < {2'b00, rd_n_ff};
  wire logic        r_in_ee  = ridx_ff < {1'b0, ee_len_ff};
  wire logic [7:0]  tx_byte  = ~resp_rdy_ff ? RESP_FILL :
                               resp_ee_ff   ? (r_in_ee ? ee_byte : RESP_FILL) :
                                              (r_in_reg ? reg_byte : RESP_FILL);

  // Two-stage synchronisers for the link inputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {cs_m_ff, cs_s_ff, cs_d_ff}    <= 3'h7;
      {sck_m_ff, sck_s_ff, sck_d_ff} <= 3'h0;
      {mosi_m_ff, mosi_s_ff}         <= 2'h0;
    end else if (ce) begin
      {cs_m_ff, cs_s_ff, cs_d_ff}    <= {link.chip_select_n, cs_m_ff, cs_s_ff};
      {sck_m_ff, sck_s_ff, sck_d_ff} <= {link.sck, sck_m_ff, sck_s_ff};
      {mosi_m_ff, mosi_s_ff}         <= {link.mosi, mosi_m_ff};
    end
  end

  // Bit shifters, most significant bit first on the wire
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bit_ff   <= 3'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= RESP_FILL;
    end else if (ce) begin
      if (!in_frame) bit_ff <= 3'h0;
      else if (sck_rise) begin
        bit_ff   <= bit_ff + 3'h1;
        rx_sh_ff <= rx_byte;
      end
      if (load_tx) tx_sh_ff <= tx_byte;
      else if (sck_fall && bit_ff != 3'h0) tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // Frame sequencing and pending response
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_ff <= IDX_OPCODE;
      ridx_ff <= 9'h000;
      pos_ff <= 3'h0;
      ent_ff <= 7'h00;
      rd_frame_ff <= 1'b0;
      resp_rdy_ff <= 1'b0;
      resp_ee_ff <= 1'b0;
    end else if (ce) begin
      if (cs_rise) begin
        cnt_ff  <= IDX_OPCODE;
        ridx_ff <= 9'h000;
        pos_ff  <= 3'h0;
        ent_ff  <= 7'h00;
        if (rd_frame_ff) begin
          rd_frame_ff <= 1'b0;
          resp_rdy_ff <= 1'b0;
        end
        if (resp_go) begin
          resp_rdy_ff <= 1'b1;
          resp_ee_ff  <= is_eer;
        end
      end else begin
        if (cs_fall) rd_frame_ff <= resp_rdy_ff;
        if (load_tx) ridx_ff <= ridx_ff + 9'h001;
        if (byte_done && cnt_ff != 9'h1FF) cnt_ff <= cnt_ff + 9'h001;
        if (par_byte && is_wrm) pos_ff <= (pos_ff == ENT_LAST) ? 3'h0 : pos_ff + 3'h1;
        if (apply_multi && ent_ff != 7'h7F) ent_ff <= ent_ff + 7'h01;
      end
    end
  end

  // Parameter capture
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      opcode_ff <= 8'h00;
      addr_ff <= 8'h00;
      act_ff <= 8'h00;
      val_ff <= 24'h000000;
      ee_ptr_ff <= 8'h00;
      ee_start_ff <= 8'h00;
      ee_len_ff <= 8'h00;
      rd_n_ff <= 5'h00;
      bad_rd_ff <= 1'b0;
      for (int i = 0; i < RD_MAX_ADDRS; i++) addr_buf_ff[i] <= 8'h00;
    end else if (ce) begin
      if (cs_rise) bad_rd_ff <= 1'b0;
      if (cmd_byte && cnt_ff == IDX_OPCODE) opcode_ff <= rx_byte;
      if (par_byte && ((is_reg_op && cnt_ff == IDX_PARAM1) || (is_wrm && pos_ff == 3'h0)))
        addr_ff <= rx_byte;
      if (par_byte && is_wrm && pos_ff == 3'h1) act_ff <= rx_byte;
      // value bytes shift in least significant first
      if (par_byte) val_ff <= {rx_byte, val_ff[23:8]};
      if (par_byte && is_eew && cnt_ff == IDX_PARAM1) ee_ptr_ff <= rx_byte;
      else if (ee_wr_en) ee_ptr_ff <= ee_ptr_ff + 8'h01;
      if (par_byte && is_eer && cnt_ff == IDX_PARAM1) ee_start_ff <= rx_byte;
      if (par_byte && is_eer && cnt_ff == IDX_PARAM2) ee_len_ff <= rx_byte;
      // up to 18 addresses kept in order
      if (rd_cap) begin
        addr_buf_ff[cap_idx] <= rx_byte;
        rd_n_ff              <= cnt_ff[4:0];
        if (rx_byte >= NREG) bad_rd_ff <= 1'b1;
      end
    end
  end

  // Register file; exception causes win over a same-cycle write
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    wire logic        hit  = wr_en & (addr_ff == 8'(g));
    wire logic [31:0] setv = (g == IRQ_STAT_IDX) ? 32'(exc_set) : 32'h0000_0000;
    always_ff @(posedge clk_sys) begin
      if (!resetn) regs_ff[g] <= REG_RESET;
      else if (ce) regs_ff[g] <= (hit ? new_val : regs_ff[g]) | setv;
    end
  end

  // EEPROM store
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < EE_DEPTH; i++) ee_ff[i] <= EE_RESET;
    end else if (ce && ee_wr_en) begin
      ee_ff[ee_ptr_ff] <= rx_byte;
    end
  end

  // Busy, interrupt and decoded instruction outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      irq_ff  <= 1'b0;
      foff_ff <= 1'b0;
      dpb_ff  <= 1'b0;
      apb_ff  <= 1'b0;
    end else if (ce) begin
      // busy set by received data, cleared after frame end
      if (byte_done) busy_ff <= 1'b1;
      else if (cs_rise) busy_ff <= 1'b0;
      irq_ff  <= |regs_ff[IRQ_STAT_IDX][EXC_W-1:0];
      foff_ff <= good_end & is_foff;
      if (good_end && is_dpb) dpb_ff <= 1'b1;
      if (good_end && is_apb) apb_ff <= 1'b1;
    end
  end

  assign link.miso               = tx_sh_ff[7];
  assign link.busy               = busy_ff;
  assign link.irq                = irq_ff;
  assign field_off_instr         = foff_ff;
  assign digital_probe_bus_instr = dpb_ff;
  assign analog_probe_bus_instr  = apb_ff;

endmodule : hrecd_dev_end

/* hdl/hrecd_pkg.sv */
// Shared constants for the host instruction decoder and its SPI host end
package hrecd_pkg;

  // ----------------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WR   = 8'h00;  // Register write
  localparam logic [7:0] OP_OR   = 8'h01;  // Register OR mask
  localparam logic [7:0] OP_AND  = 8'h02;  // Register AND mask
  localparam logic [7:0] OP_WRM  = 8'h03;  // Multi-register write
  localparam logic [7:0] OP_RD   = 8'h04;  // Register read
  localparam logic [7:0] OP_RDM  = 8'h05;  // Multi-register read
  localparam logic [7:0] OP_EEW  = 8'h06;  // EEPROM write
  localparam logic [7:0] OP_EER  = 8'h07;  // EEPROM read
  localparam logic [7:0] OP_FOFF = 8'h17;  // Field off
  localparam logic [7:0] OP_DPB  = 8'h18;  // Digital probe bus enable
  localparam logic [7:0] OP_APB  = 8'h19;  // Analog probe bus enable

  // Actions of a multi-register write entry
  localparam logic [7:0] ACT_WR  = 8'h01;
  localparam logic [7:0] ACT_OR  = 8'h02;
  localparam logic [7:0] ACT_AND = 8'h03;

  // ----------------------------------------------------------------------
  // Frame layout (byte index 0 is the opcode)
  // ----------------------------------------------------------------------
  localparam logic [8:0] IDX_OPCODE      = 9'h000;
  localparam logic [8:0] IDX_PARAM1      = 9'h001;
  localparam logic [8:0] IDX_PARAM2      = 9'h002;
  localparam logic [8:0] IDX_WR_LAST     = 9'h005;
  localparam logic [8:0] WR_FRAME_LEN    = 9'h006;
  localparam logic [8:0] RD_FRAME_LEN    = 9'h002;
  localparam logic [8:0] RDM_FRAME_MAX   = 9'h013;  // Opcode plus 18 addresses
  localparam logic [8:0] EEW_FRAME_MIN   = 9'h003;
  localparam logic [8:0] EER_FRAME_LEN   = 9'h003;
  localparam logic [8:0] SHORT_FRAME_LEN = 9'h002;
  localparam logic [2:0] ENT_LAST        = 3'h5;    // Six bytes per entry
  localparam logic [6:0] MAX_ENTRIES     = 7'h2A;   // 42 entries
  localparam int         RD_MAX_ADDRS    = 18;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  localparam int          REG_COUNT     = 16;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam int          IRQ_STAT_IDX  = 0;
  localparam int          EE_DEPTH      = 255;
  localparam logic [7:0]  EE_LAST_ADDR  = 8'hFE;
  localparam logic [8:0]  EE_END_EXCL   = 9'h0FF;
  localparam logic [7:0]  EE_RESET      = 8'hFF;
  localparam logic [7:0]  RESP_FILL     = 8'h00;

  // Exception causes in the interrupt status register
  localparam int EXC_W       = 4;
  localparam int EXC_OPCODE  = 0;
  localparam int EXC_ADDRESS = 1;
  localparam int EXC_LENGTH  = 2;
  localparam int EXC_ACTION  = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS   = 800;
  localparam int SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;

endpackage : hrecd_pkg

/* hdl/hrecd_link_if.sv */
// SPI link between the host end and the instruction decoder end
`timescale 1ns/1ps
interface hrecd_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic chip_select_n;
  logic busy;
  logic irq;

  modport dev  (input sck, input mosi, input chip_select_n,
                output miso, output busy, output irq);
  modport host (output sck, output mosi, output chip_select_n,
                input miso, input busy, input irq);
endinterface : hrecd_link_if

/* hdl/hrecd_host_end.sv */
// SPI host end: sends byte frames and keeps the busy handshake
`timescale 1ns/1ps
module hrecd_host_end
  import hrecd_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  // System
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Link
  hrecd_link_if.host      link,
  // Byte stream to send
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Received bytes and status
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            frame_done,
  output logic            irq_seen
);

  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

  typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_WHI, H_WLO} hrecd_hst_t;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  hrecd_hst_t st_ff;
  logic [7:0] div_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] rx_data_ff;
  logic       last_ff, sck_ff, cs_n_ff, rx_v_ff, done_ff;
  logic       miso_m_ff, miso_s_ff, busy_m_ff, busy_s_ff, irq_m_ff, irq_s_ff;

  wire logic half_up = div_ff == HALF_M1;

  // Synchronisers for device outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {miso_m_ff, miso_s_ff, busy_m_ff, busy_s_ff, irq_m_ff, irq_s_ff} <= 6'h00;
    end else if (ce) begin
      {miso_m_ff, miso_s_ff} <= {link.miso, miso_m_ff};
      {busy_m_ff, busy_s_ff} <= {link.busy, busy_m_ff};
      {irq_m_ff, irq_s_ff}   <= {link.irq, irq_m_ff};
    end
  end

  // Frame engine, clock divided from the system clock, SPI mode 0
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_ff <= H_IDLE;
      div_ff <= 8'h00;
      bit_ff <= 3'h0;
      sh_ff <= 8'h00;
      rx_sh_ff <= 8'h00;
      rx_data_ff <= 8'h00;
      last_ff <= 1'b0;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      rx_v_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      rx_v_ff <= 1'b0;
      done_ff <= 1'b0;
      unique case (st_ff)
        H_IDLE: begin
          if (tx_valid) begin
            cs_n_ff <= 1'b0;
            st_ff   <= H_LOAD;
          end
        end
        // chip select held low while waiting for more bytes
        H_LOAD: begin
          if (tx_valid) begin
            sh_ff   <= tx_data;
            last_ff <= tx_last;
            bit_ff  <= 3'h0;
            div_ff  <= 8'h00;
            st_ff   <= H_LOW;
          end
        end
        H_LOW: begin
          div_ff <= div_ff + 8'h01;
          if (half_up) begin
            div_ff   <= 8'h00;
            sck_ff   <= 1'b1;
            rx_sh_ff <= {rx_sh_ff[6:0], miso_s_ff};
            st_ff    <= H_HIGH;
          end
        end
        H_HIGH: begin
          div_ff <= div_ff + 8'h01;
          if (half_up) begin
            div_ff <= 8'h00;
            sck_ff <= 1'b0;
            if (bit_ff == BIT_LAST) begin
              rx_v_ff    <= 1'b1;
              rx_data_ff <= rx_sh_ff;
              st_ff      <= last_ff ? H_WHI : H_LOAD;
            end else begin
              bit_ff <= bit_ff + 3'h1;
              sh_ff  <= {sh_ff[6:0], 1'b0};
              st_ff  <= H_LOW;
            end
          end
        end
        // wait busy high, release select, wait busy low
        H_WHI: begin
          if (busy_s_ff) begin
            cs_n_ff <= 1'b1;
            st_ff   <= H_WLO;
          end
        end
        H_WLO: begin
          if (!busy_s_ff) begin
            done_ff <= 1'b1;
            st_ff   <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_ready           = ce & (st_ff == H_LOAD);
  assign link.sck           = sck_ff;
  assign link.mosi          = sh_ff[7];
  assign link.chip_select_n = cs_n_ff;
  assign rx_valid           = rx_v_ff;
  assign rx_data            = rx_data_ff;
  assign frame_done         = done_ff;
  assign irq_seen           = irq_s_ff;

endmodule : hrecd_host_end

/* tb/hrecd_asserts.sv */
// Link checker for the host end and the decoder end
`timescale 1ns/1ps
module hrecd_asserts (
  // System
  input wire logic clk_sys,
  input wire logic resetn,
  // Link
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic chip_select_n,
  input wire logic busy,
  input wire logic irq
);
  localparam int BYTE_MAX = 300;  // Cycles allowed for one byte plus sync delay
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_sck_idle_low: assert property (chip_select_n |-> !sck) else $error("sck high outside frame");
  a_mosi_steady: assert property (sck |-> $stable(mosi)) else $error("mosi moved, sck high");
  a_cs_after_busy: assert property ($rose(chip_select_n) |-> busy) else $error("cs rose early");
  a_busy_falls: assert property ($rose(chip_select_n) |-> ##[1:8] !busy) else $error("busy stuck");
  a_busy_held: assert property ($fell(busy) |-> chip_select_n) else $error("busy fell in frame");
  a_busy_start_low: assert property ($fell(chip_select_n) |-> !busy) else $error("busy at start");
  a_busy_rises: assert property ($fell(chip_select_n) |-> ##[1:BYTE_MAX] busy) else $error("no busy");
  // exception raised by a received frame
  a_irq_by_frame: assert property ($rose(irq) |-> $past(busy, 2)) else $error("stray irq");
endmodule : hrecd_asserts

/* tb/testbench.sv */
// Bench driving the host end against the decoder end over one link
`timescale 1ns/1ps
module testbench;
  typedef struct {int n; logic [159:0] f; int rn; logic [95:0] e; logic [3:0] st;} hrecd_row_t;
  logic       clk_sys, resetn, tx_valid, tx_last, tx_ready, rx_valid, frame_done, irq_seen;
  logic       field_off, dig_probe, ana_probe, off_seen;
  logic [7:0] tx_data, rx_data, rq[$];
  int         err_total = 0, num_checks = 0;
  hrecd_row_t rows[17];
  hrecd_link_if link ();
  hrecd_dev_end u_hrecd_dev_end (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .link(link),
    .field_off_instr(field_off), .digital_probe_bus_instr(dig_probe),
    .analog_probe_bus_instr(ana_probe));
  hrecd_host_end #(.SCK_HALF(6)) u_hrecd_host_end (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .link(link), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .frame_done(frame_done), .irq_seen(irq_seen));
  hrecd_asserts u_hrecd_asserts (.clk_sys(clk_sys), .resetn(resetn), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .chip_select_n(link.chip_select_n), .busy(link.busy),
    .irq(link.irq));
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Collect received bytes, remember the field-off pulse
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) rq.push_back(rx_data);
    if (field_off === 1'b1) off_seen = 1'b1;
  end
  // Compare one byte-wide result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Print counts and verdict, then stop
  task automatic test_done(input logic hung);
    if (hung) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
    end
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Send one frame, byte i taken from f[8i+7:8i], then wait for frame end
  task automatic frame(input int n, input logic [159:0] f);
    int t;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_sys);
      {tx_valid, tx_last, tx_data} = {i < n, i == n - 1, f[8*i +: 8]};
      for (t = 0; i < n && tx_ready !== 1'b1; t++) begin
        @(negedge clk_sys);
        if (t > 400) test_done(1'b1);
      end
    end
    for (t = 0; frame_done !== 1'b1; t++) begin
      @(negedge clk_sys);
      if (t > 3000) test_done(1'b1);
    end
    repeat (4) @(negedge clk_sys);
  endtask : frame
  // Instruction frame, read frame when a response is due, then compare
  task automatic run(input int n, input logic [159:0] f, input int rn, input logic [95:0] e,
                     input logic [3:0] st);
    frame(n, f);
    rq.delete();
    if (rn > 0) frame(rn, 160'h0);
    chk(8'(rq.size()), 8'(rn));
    for (int i = 0; i < rn; i++) chk(rq[i], e[8*i +: 8]);
    chk({4'h0, off_seen, dig_probe, ana_probe, irq_seen}, {4'h0, st});
  endtask : run
  // Main sequence
  initial begin
    {resetn, tx_valid, tx_last, off_seen, tx_data} = 12'h000;
    rows = '{
      '{6, 160'h11223344_01_00, 0, 96'h0, 4'h0}, '{6, 160'hF0000000_01_01, 0, 96'h0, 4'h0},
      '{6, 160'hFF0FFFFF_01_02, 0, 96'h0, 4'h0}, '{2, 160'h01_04, 4, 96'hF1023344, 4'h0},
      '{19, 160'h000000A5_02_03_FFFFFF0F_03_02_12345678_01_02_03, 0, 96'h0, 4'h0},
      '{4, 160'h01_02_03_05, 12, 96'hF1023344_12345608_000000A5, 4'h0},
      '{4, 160'hCD_AB_FD_06, 0, 96'h0, 4'h0}, '{3, 160'h03_FC_07, 3, 96'hCDABFF, 4'h0},
      '{2, 160'h00_17, 0, 96'h0, 4'h8}, '{2, 160'h00_18, 0, 96'h0, 4'hC},
      '{2, 160'h00_19, 0, 96'h0, 4'hE}, '{2, 160'h00_0F, 0, 96'h0, 4'hF},
      '{6, 160'h44332211_20_00, 0, 96'h0, 4'hF}, '{2, 160'h00_04, 4, 96'h3, 4'hF},
      '{6, 160'h0, 0, 96'h0, 4'hE}, '{2, 160'h05_04, 4, 96'h0, 4'hE},
      '{13, 160'h00000000_07_05_00000011_01_05_03, 0, 96'h0, 4'hF}};
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    chk({6'h00, link.chip_select_n, link.busy}, 8'h02);
    for (int i = 0; i < 17; i++) begin
      run(rows[i].n, rows[i].f, rows[i].rn, rows[i].e, rows[i].st);
    end
    // entry before a bad action stays written
    run(2, 160'h05_04, 4, 96'h11, 4'hF);
    // bad range and wrong length raise causes
    run(6, 160'h0, 0, 96'h0, 4'hE);
    run(3, 160'h02_FE_07, 0, 96'h0, 4'hF);
    run(3, 160'h00_00_04, 0, 96'h0, 4'hF);
    run(2, 160'h00_04, 4, 96'h6, 4'hF);
    // mid-run reset clears link, status and probe enables
    @(negedge clk_sys);
    {resetn, off_seen} = 2'b00;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    chk({4'h0, link.chip_select_n, link.busy, dig_probe, ana_probe}, 8'h08);
    run(2, 160'h01_04, 4, 96'h0, 4'h0);
    test_done(1'b0);
  end
endmodule : testbench
